/* verilog/rusm_pkg.sv */
// Shared constants and carrier types for the radio UART status and mode control block
package rusm_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned BUF_BYTES = 400;
    localparam int unsigned PTR_W = 9;
    localparam int unsigned MODE_SETTLE_US = 1000;
    localparam int unsigned MODE_SETTLE_CYC = (CLK_HZ / 1000000) * MODE_SETTLE_US;
    localparam int unsigned HIGH_HOLD_US = 2000;
    localparam int unsigned HIGH_HOLD_CYC = (CLK_HZ / 1000000) * HIGH_HOLD_US;
    localparam int unsigned SELFCHECK_CYC_DEF = 1000;
    localparam int unsigned RELOAD_CYC_DEF = 500;
    localparam int unsigned CNT_W = 20;
    localparam logic [15:0] ADDR_BCAST_HI = 16'hFFFF;
    localparam logic [15:0] ADDR_BCAST_LO = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_RST = 9'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

    typedef enum logic [1:0]
    {
        RUSM_MODE_NORMAL = 2'h0,
        RUSM_MODE_WAKE_TX = 2'h1,
        RUSM_MODE_WAKE_RX = 2'h2,
        RUSM_MODE_SLEEP = 2'h3
    } rusm_mode_t;

    typedef enum logic [1:0]
    {
        RUSM_ST_INIT = 2'h0,
        RUSM_ST_RUN = 2'h1,
        RUSM_ST_HOLD = 2'h3,
        RUSM_ST_RELOAD = 2'h2
    } rusm_state_t;

    typedef struct packed
    {
        logic valid;
        logic [7:0] data;
    } rusm_byte_t;
endpackage

/* verilog/rusm_ctrl.sv */
// Status output, mode gating, transmit buffer and receive path of the radio UART module
`timescale 1ns/10ps
module rusm_ctrl #(
    parameter int unsigned SELFCHECK_CYC = rusm_pkg::SELFCHECK_CYC_DEF,
    parameter int unsigned RELOAD_CYC = rusm_pkg::RELOAD_CYC_DEF,
    parameter int unsigned SETTLE_CYC = rusm_pkg::MODE_SETTLE_CYC,
    parameter int unsigned HOLD_CYC = rusm_pkg::HIGH_HOLD_CYC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic mode_select_low_in,
    input wire logic mode_select_high_in,
    input wire logic serial_rx_in,
    input wire logic [15:0] own_addr_in,
    input wire rusm_pkg::rusm_byte_t host_byte_in,
    output logic host_ready_out,
    output rusm_pkg::rusm_byte_t radio_byte_out,
    input wire logic radio_ready_in,
    output logic radio_last_out,
    output logic radio_bcast_out,
    input wire rusm_pkg::rusm_byte_t air_byte_in,
    input wire logic [15:0] air_src_addr_in,
    input wire logic [15:0] air_dst_addr_in,
    output logic air_ready_out,
    output rusm_pkg::rusm_byte_t uart_byte_out,
    input wire logic uart_ready_in,
    input wire logic uart_tx_busy_in,
    input wire logic serial_tx_in,
    output logic serial_tx_out,
    output logic serial_rx_sync_out,
    output logic status_out,
    output rusm_pkg::rusm_mode_t mode_out,
    output logic reload_out
);
    // Synchronisers, first stage read only by second
    logic [1:0] sel_s1_r, sel_s2_r, sel_s1_nxt, sel_s2_nxt;
    logic rx_s1_r, rx_s2_r, rx_s1_nxt, rx_s2_nxt;
    always_comb
    begin
        sel_s1_nxt = {mode_select_high_in, mode_select_low_in};
        sel_s2_nxt = sel_s1_r;
        rx_s1_nxt = serial_rx_in;
        rx_s2_nxt = rx_s1_r;
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            // Pulled-up level, so pins read as sleep until sampled
            sel_s1_r <= 2'h3;
            sel_s2_r <= 2'h3;
            rx_s1_r <= 1'h1;
            rx_s2_r <= 1'h1;
        end
        else
        begin
            sel_s1_r <= sel_s1_nxt;
            sel_s2_r <= sel_s2_nxt;
            rx_s1_r <= rx_s1_nxt;
            rx_s2_r <= rx_s2_nxt;
        end
    end
    assign serial_rx_sync_out = rx_s2_r;

    // Transmit buffer, 400 entries of flip-flops
    logic [7:0] mem_r [rusm_pkg::BUF_BYTES];
    logic [rusm_pkg::PTR_W-1:0] wp_r, rp_r, cnt_r, wp_nxt, rp_nxt, cnt_nxt;
    logic push, pop, buf_full, buf_empty;
    assign buf_full = (cnt_r == rusm_pkg::PTR_W'(rusm_pkg::BUF_BYTES));
    assign buf_empty = (cnt_r == rusm_pkg::PTR_RST);
    assign host_ready_out = !buf_full;
    assign push = host_byte_in.valid && !buf_full;
    assign pop = !buf_empty && radio_ready_in;
    always_comb
    begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push)
            wp_nxt = (wp_r == rusm_pkg::PTR_W'(rusm_pkg::BUF_BYTES - 1)) ? rusm_pkg::PTR_RST
                : wp_r + 9'h001;
        if (pop)
            rp_nxt = (rp_r == rusm_pkg::PTR_W'(rusm_pkg::BUF_BYTES - 1)) ? rusm_pkg::PTR_RST
                : rp_r + 9'h001;
        // Slot freed as soon as radio takes it, packet may still be on air
        if (push && !pop)
            cnt_nxt = cnt_r + 9'h001;
        else if (pop && !push)
            cnt_nxt = cnt_r - 9'h001;
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wp_r <= rusm_pkg::PTR_RST;
            rp_r <= rusm_pkg::PTR_RST;
            cnt_r <= rusm_pkg::PTR_RST;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    always_ff @(posedge clock_in)
    begin
        // Storage has no reset; only pointers and count need one
        if (push)
            mem_r[wp_r] <= host_byte_in.data;
    end
    always_comb
    begin
        radio_byte_out.valid = !buf_empty;
        radio_byte_out.data = mem_r[rp_r];
        radio_last_out = (cnt_r == 9'h001);
        radio_bcast_out = (own_addr_in == rusm_pkg::ADDR_BCAST_HI)
            || (own_addr_in == rusm_pkg::ADDR_BCAST_LO);
    end

    // Two-entry receive skid buffer, address filter ahead of it
    logic [7:0] sk_d_r [2];
    logic [1:0] sk_n_r, sk_n_nxt;
    logic sk_h_r, sk_h_nxt;
    logic air_hit, air_push, uart_pop;
    assign air_hit = radio_bcast_out || (air_dst_addr_in == own_addr_in)
        || (air_dst_addr_in == rusm_pkg::ADDR_BCAST_HI)
        || (air_dst_addr_in == rusm_pkg::ADDR_BCAST_LO);
    assign air_ready_out = (sk_n_r != 2'h2);
    assign air_push = air_byte_in.valid && air_ready_out && air_hit;
    assign uart_pop = (sk_n_r != 2'h0) && uart_ready_in;
    always_comb
    begin
        sk_n_nxt = sk_n_r;
        sk_h_nxt = sk_h_r;
        if (air_push && !uart_pop)
            sk_n_nxt = sk_n_r + 2'h1;
        else if (uart_pop && !air_push)
            sk_n_nxt = sk_n_r - 2'h1;
        if (uart_pop)
            sk_h_nxt = !sk_h_r;
        uart_byte_out.valid = (sk_n_r != 2'h0);
        uart_byte_out.data = sk_d_r[sk_h_r];
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sk_n_r <= 2'h0;
            sk_h_r <= 1'h0;
        end
        else
        begin
            sk_n_r <= sk_n_nxt;
            sk_h_r <= sk_h_nxt;
        end
    end
    always_ff @(posedge clock_in)
    begin
        // Write slot is head plus count, modulo two
        if (air_push)
            sk_d_r[sk_h_r ^ sk_n_r[0]] <= air_byte_in.data;
    end
    logic air_src_unused;
    assign air_src_unused = ^air_src_addr_in;

    // Mode and status sequencer
    rusm_pkg::rusm_state_t st_r, st_nxt;
    rusm_pkg::rusm_mode_t mode_r, mode_nxt, pend_r, pend_nxt;
    logic [rusm_pkg::CNT_W-1:0] tmr_r, tmr_nxt;
    logic busy_tx, busy_rx, stat_r, stat_nxt;
    assign busy_tx = !buf_empty;
    assign busy_rx = (sk_n_r != 2'h0) || uart_tx_busy_in;
    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        pend_nxt = pend_r;
        tmr_nxt = tmr_r;
        case (st_r)
            rusm_pkg::RUSM_ST_INIT:
            begin
                // Self-check only here after reset; sleep exit goes through reload instead
                if (tmr_r >= rusm_pkg::CNT_W'(SELFCHECK_CYC - 1))
                begin
                    st_nxt = rusm_pkg::RUSM_ST_RUN;
                    mode_nxt = rusm_pkg::rusm_mode_t'(sel_s2_r);
                    pend_nxt = rusm_pkg::rusm_mode_t'(sel_s2_r);
                    tmr_nxt = rusm_pkg::CNT_RST;
                end
                else
                    tmr_nxt = tmr_r + 20'h00001;
            end
            rusm_pkg::RUSM_ST_RUN:
            begin
                // Selects sampled only while status is high
                if (stat_r && (rusm_pkg::rusm_mode_t'(sel_s2_r) != mode_r))
                begin
                    pend_nxt = rusm_pkg::rusm_mode_t'(sel_s2_r);
                    tmr_nxt = rusm_pkg::CNT_RST;
                    if (mode_r == rusm_pkg::RUSM_MODE_SLEEP)
                        st_nxt = rusm_pkg::RUSM_ST_RELOAD;
                    else if (tmr_r >= rusm_pkg::CNT_W'(HOLD_CYC))
                        mode_nxt = rusm_pkg::rusm_mode_t'(sel_s2_r);
                    else
                        st_nxt = rusm_pkg::RUSM_ST_HOLD;
                end
                else if (!stat_r)
                    tmr_nxt = rusm_pkg::CNT_RST;
                else if (tmr_r < rusm_pkg::CNT_W'(HOLD_CYC))
                    tmr_nxt = tmr_r + 20'h00001;
            end
            rusm_pkg::RUSM_ST_HOLD:
            begin
                // Wait out the post-low settle, restart if status drops again
                if (!stat_r)
                    tmr_nxt = rusm_pkg::CNT_RST;
                else if (tmr_r >= rusm_pkg::CNT_W'(HOLD_CYC - 1))
                begin
                    st_nxt = rusm_pkg::RUSM_ST_RUN;
                    mode_nxt = pend_r;
                end
                else
                    tmr_nxt = tmr_r + 20'h00001;
            end
            rusm_pkg::RUSM_ST_RELOAD:
            begin
                if (tmr_r >= rusm_pkg::CNT_W'(RELOAD_CYC - 1))
                begin
                    st_nxt = rusm_pkg::RUSM_ST_RUN;
                    mode_nxt = pend_r;
                    tmr_nxt = rusm_pkg::CNT_RST;
                end
                else
                    tmr_nxt = tmr_r + 20'h00001;
            end
            default:
            begin
                st_nxt = rusm_pkg::RUSM_ST_INIT;
                tmr_nxt = rusm_pkg::CNT_RST;
            end
        endcase
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= rusm_pkg::RUSM_ST_INIT;
            mode_r <= rusm_pkg::RUSM_MODE_SLEEP;
            pend_r <= rusm_pkg::RUSM_MODE_SLEEP;
            tmr_r <= rusm_pkg::CNT_RST;
        end
        else
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            tmr_r <= tmr_nxt;
        end
    end
    // Status follows the next state, so self-check and reload read low from their first cycle
    always_comb
    begin
        stat_nxt = !(busy_tx || busy_rx);
        if ((st_nxt == rusm_pkg::RUSM_ST_INIT) || (st_nxt == rusm_pkg::RUSM_ST_RELOAD))
            stat_nxt = 1'h0;
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            stat_r <= 1'h0;
        else
            stat_r <= stat_nxt;
    end
    // Registered status, so one cycle behind the busy terms
    assign status_out = stat_r;
    assign mode_out = mode_r;
    assign reload_out = (st_r == rusm_pkg::RUSM_ST_RELOAD);
    assign serial_tx_out = serial_tx_in;
endmodule // rusm_ctrl

/* testbench/rusm_ctrl_chk.sv */
// Port checker for the radio UART status and mode control block
`timescale 1ns/10ps
module rusm_ctrl_chk #(
    parameter int unsigned SELFCHECK_CYC = 20,
    parameter int unsigned HOLD_CYC = 20
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic serial_rx_in,
    input wire logic [15:0] own_addr_in,
    input wire rusm_pkg::rusm_byte_t radio_byte_out,
    input wire logic radio_bcast_out,
    input wire rusm_pkg::rusm_byte_t uart_byte_out,
    input wire logic uart_tx_busy_in,
    input wire logic serial_tx_in,
    input wire logic serial_tx_out,
    input wire logic serial_rx_sync_out,
    input wire logic status_out,
    input wire rusm_pkg::rusm_mode_t mode_out,
    input wire logic reload_out
);
    logic [19:0] age_r, age_nxt, hi_r, hi_nxt;
    // Saturate so long runs never wrap
    always_comb
    begin
        age_nxt = (age_r == 20'hFFFFF) ? age_r : age_r + 20'h00001;
        hi_nxt = !status_out ? 20'h00000 : (hi_r == 20'hFFFFF) ? hi_r : hi_r + 20'h00001;
    end
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            {age_r, hi_r} <= 40'h0000000000;
        else
            {age_r, hi_r} <= {age_nxt, hi_nxt};
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_init;
        age_r < SELFCHECK_CYC |-> !status_out;
    endproperty
    a_init: assert property (p_init) else $error("status high in self-check");
    property p_buf;
        radio_byte_out.valid |=> !status_out;
    endproperty
    a_buf: assert property (p_buf) else $error("status high with bytes queued");
    property p_uart;
        uart_byte_out.valid || uart_tx_busy_in |=> !status_out;
    endproperty
    a_uart: assert property (p_uart) else $error("status high while serial out");
    property p_rld;
        reload_out |-> !status_out;
    endproperty
    a_rld: assert property (p_rld) else $error("status high in reload");
    property p_rldlen;
        $rose(reload_out) |-> reload_out [*8];
    endproperty
    a_rldlen: assert property (p_rldlen) else $error("reload too short");
    property p_rldsrc;
        $rose(reload_out) |-> mode_out == rusm_pkg::RUSM_MODE_SLEEP;
    endproperty
    a_rldsrc: assert property (p_rldsrc) else $error("reload not from sleep");
    // Slack of two cycles covers the register stages around the hold count
    property p_hold;
        $changed(mode_out) && $past(mode_out) != rusm_pkg::RUSM_MODE_SLEEP
            |-> $past(hi_r) >= HOLD_CYC - 2;
    endproperty
    a_hold: assert property (p_hold) else $error("mode applied early");
    property p_sync;
        !$past(rst_in) && !$past(rst_in, 2) |-> serial_rx_sync_out == $past(serial_rx_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("serial input sync depth");
    property p_tx;
        serial_tx_out == serial_tx_in;
    endproperty
    a_tx: assert property (p_tx) else $error("serial output differs");
    property p_bc;
        radio_bcast_out == (own_addr_in == 16'hFFFF || own_addr_in == 16'h0000);
    endproperty
    a_bc: assert property (p_bc) else $error("broadcast flag wrong");
    c_rld: cover property ($rose(reload_out));
    c_mode: cover property ($changed(mode_out) && $past(mode_out) != rusm_pkg::RUSM_MODE_SLEEP);
    c_busy: cover property (radio_byte_out.valid && !status_out);
endmodule // rusm_ctrl_chk
bind rusm_ctrl rusm_ctrl_chk #(.SELFCHECK_CYC(SELFCHECK_CYC), .HOLD_CYC(HOLD_CYC)) rusm_ctrl_chk_inst (
    .clock_in, .rst_in, .serial_rx_in, .own_addr_in, .radio_byte_out, .radio_bcast_out,
    .uart_byte_out, .uart_tx_busy_in, .serial_tx_in, .serial_tx_out, .serial_rx_sync_out,
    .status_out, .mode_out, .reload_out);

/* testbench/rusm_far_model.sv */
// Far side model: radio sink and UART transmitter, both able to stall
`timescale 1ns/10ps
module rusm_far_model (
    input wire logic clock_in,
    input wire logic hold_in,
    input wire logic slow_in,
    input wire logic uart_valid_in,
    output logic radio_ready_out,
    output logic uart_ready_out,
    output logic uart_busy_out,
    output logic serial_tx_out
);
    int busy_cnt = 0;
    initial {radio_ready_out, uart_ready_out, uart_busy_out, serial_tx_out} = 4'h1;
    always @(posedge clock_in)
    begin
        radio_ready_out <= !hold_in && (!slow_in || $urandom_range(1));
        if (uart_valid_in && uart_ready_out)
            busy_cnt <= 6;
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
        uart_ready_out <= busy_cnt == 0 && !(uart_valid_in && uart_ready_out);
        uart_busy_out <= busy_cnt > 1 || (uart_valid_in && uart_ready_out);
        // Line idles high, toggles during a frame
        serial_tx_out <= (busy_cnt != 0) ? ~serial_tx_out : 1'b1;
    end
endmodule // rusm_far_model

/* testbench/rusm_ctrl_bench.sv */
// Self-checking bench for the radio UART status and mode control block
`timescale 1ns/10ps
`define CHK(a, b) begin logic [31:0] g_v, e_v; g_v = 32'(a); e_v = 32'(b); checked++; \
    if (g_v !== e_v) begin errors++; $display("BAD %0t %h %h", $time, g_v, e_v); end end
module rusm_ctrl_bench;
    logic clock_in = 1'b0, rst_in = 1'b1, m_lo = 1'b0, m_hi = 1'b0, rx = 1'b1;
    logic hold = 1'b0, slow = 1'b0, host_ready, radio_ready, radio_last, bcast, air_ready;
    logic uart_ready, uart_busy, stx_in, stx_out, rx_sync, status, reload;
    logic [15:0] own_addr = 16'h0001, air_dst = 16'h0000;
    rusm_pkg::rusm_byte_t host_b = '0, air_b = '0, radio_b, uart_b;
    rusm_pkg::rusm_mode_t mode;
    int errors = 0, checked = 0;
    logic [7:0] rq[$], uq[$];
    logic [15:0] owns [6] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'hFFFF, 16'h0000};
    logic [15:0] dsts [6] = '{16'h0001, 16'h0005, 16'hFFFF, 16'h0000, 16'h0007, 16'h1234};
    logic [5:0] accs = 6'h3D;
    rusm_ctrl #(.SELFCHECK_CYC(20), .RELOAD_CYC(10), .HOLD_CYC(20)) rusm_ctrl_inst (
        .clock_in(clock_in), .rst_in(rst_in), .mode_select_low_in(m_lo),
        .mode_select_high_in(m_hi), .serial_rx_in(rx), .own_addr_in(own_addr),
        .host_byte_in(host_b), .host_ready_out(host_ready), .radio_byte_out(radio_b),
        .radio_ready_in(radio_ready), .radio_last_out(radio_last), .radio_bcast_out(bcast),
        .air_byte_in(air_b), .air_src_addr_in(16'h0000), .air_dst_addr_in(air_dst),
        .air_ready_out(air_ready), .uart_byte_out(uart_b), .uart_ready_in(uart_ready),
        .uart_tx_busy_in(uart_busy), .serial_tx_in(stx_in), .serial_tx_out(stx_out),
        .serial_rx_sync_out(rx_sync), .status_out(status), .mode_out(mode), .reload_out(reload));
    rusm_far_model rusm_far_model_inst (.clock_in(clock_in), .hold_in(hold), .slow_in(slow),
        .uart_valid_in(uart_b.valid), .radio_ready_out(radio_ready),
        .uart_ready_out(uart_ready), .uart_busy_out(uart_busy), .serial_tx_out(stx_in));
    initial forever #10 clock_in = ~clock_in;
    always @(posedge clock_in) rx <= 1'($urandom_range(1));
    // Results appear at pops; oldest note is compared
    always @(posedge clock_in)
    begin
        if (radio_b.valid && radio_ready)
            `CHK(radio_b.data, rq.pop_front())
        if (uart_b.valid && uart_ready)
            `CHK(uart_b.data, uq.pop_front())
    end
    task automatic complete_run();
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic guard(input int n, input int lim);
        if (n >= lim)
        begin
            errors++;
            complete_run();
        end
    endtask
    task automatic wait_mode(input rusm_pkg::rusm_mode_t m);
        int n;
        for (n = 0; !(mode === m && status === 1'b1) && n < 3000; n++)
            @(posedge clock_in);
        guard(n, 3000);
    endtask
    task automatic set_mode(input rusm_pkg::rusm_mode_t m);
        {m_hi, m_lo} <= m;
        wait_mode(m);
        `CHK(mode, m)
    endtask
    // Waits for the taking edge; data and valid held until then
    task automatic put(input logic [7:0] d);
        int n;
        host_b <= {1'b1, d};
        for (n = 0; n == 0 || (host_ready !== 1'b1 && n < 2000); n++)
            @(posedge clock_in);
        guard(n, 2000);
        rq.push_back(d);
    endtask
    initial
    begin
        int n;
        logic [7:0] d;
        void'($urandom(32'h9CAE47AB));
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        `CHK(status, 1'b0)
        wait_mode(rusm_pkg::RUSM_MODE_NORMAL);
        `CHK(mode, rusm_pkg::RUSM_MODE_NORMAL)
        set_mode(rusm_pkg::RUSM_MODE_WAKE_RX);
        set_mode(rusm_pkg::RUSM_MODE_SLEEP);
        {m_hi, m_lo} <= 2'h0;
        for (n = 0; reload !== 1'b1 && n < 50; n++)
            @(posedge clock_in);
        guard(n, 50);
        `CHK(status, 1'b0)
        set_mode(rusm_pkg::RUSM_MODE_NORMAL);
        slow <= 1'b1;
        repeat (30) put(8'($urandom));
        host_b <= '0;
        wait_mode(rusm_pkg::RUSM_MODE_NORMAL);
        `CHK(rq.size(), 0)
        hold <= 1'b1;
        repeat (4) @(posedge clock_in);
        n = 0;
        do
        begin
            host_b <= {1'b1, 8'(n)};
            @(posedge clock_in);
            if (n == 1)
                `CHK(radio_last, 1'b1)
            if (host_ready === 1'b1)
                rq.push_back(8'(n));
            n++;
        end
        while (host_ready === 1'b1 && n < 500);
        host_b <= '0;
        `CHK(n - 1, rusm_pkg::BUF_BYTES)
        `CHK(radio_last, 1'b0)
        {m_hi, m_lo} <= 2'h1;
        repeat (8) @(posedge clock_in);
        `CHK(mode, rusm_pkg::RUSM_MODE_NORMAL)
        hold <= 1'b0;
        wait_mode(rusm_pkg::RUSM_MODE_WAKE_TX);
        `CHK(rq.size(), 0)
        for (int i = 0; i < 6; i++)
        begin
            own_addr <= owns[i];
            air_dst <= dsts[i];
            d = 8'($urandom);
            air_b <= {1'b1, d};
            for (n = 0; n == 0 || (air_ready !== 1'b1 && n < 2000); n++)
                @(posedge clock_in);
            guard(n, 2000);
            if (accs[i])
                uq.push_back(d);
        end
        air_b <= '0;
        repeat (4) @(posedge clock_in);
        wait_mode(rusm_pkg::RUSM_MODE_WAKE_TX);
        `CHK(uq.size(), 0)
        complete_run();
    end
endmodule // rusm_ctrl_bench
